// ===== pkg/cbu_br_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cbu_br_if;
  import cbu_pkg::*;
  cbu_op_t op; // Selected branch
  logic [FLG_W-1:0] flags; // Status flag snapshot
  logic [OFS_W-1:0] offset; // Raw relative offset
  logic [PC_W-1:0] pc; // Current program counter
  logic taken; // Condition holds
  logic [PC_W-1:0] target; // Jump destination
  // Sequencer side
  modport ctl (output op, flags, offset, pc, input taken, target);
  // Condition evaluator side
  modport eval (input op, flags, output taken);
  // Target adder side
  modport add (input offset, pc, output target);
endinterface
`default_nettype wire

// ===== pkg/cbu_pkg.sv
package cbu_pkg;

  // Datapath widths
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int FLG_W = 8;
  localparam int OP_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_FLG = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_PC = 8'h0C;
  localparam logic [ADDR_W-1:0] ADR_STAT = 8'h10;

  // Control register layout
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 8;

  // Status flag positions, same order as the core status byte
  localparam int FLG_C = 0;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  // Flags this unit looks at; the others read as zero
  localparam logic [FLG_W-1:0] FLG_MASK = 8'h6D;

  // Status register layout
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_CYC_LSB = 2;
  localparam int CYC_W = 2;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [OFS_W-1:0] OFS_RST = 7'h00;
  localparam logic [FLG_W-1:0] FLG_RST = 8'h00;

  // Program counter step of one word
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;

  // Timing: clock period and cycles per branch outcome
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [CYC_W-1:0] CYC_FALL = 2'h1;
  localparam logic [CYC_W-1:0] CYC_TAKEN = 2'h2;

  // Branch selector written into the control register
  typedef enum logic [OP_W-1:0] {
    branch_if_unsigned_lower = 3'h0,
    branch_if_negative = 3'h1,
    branch_if_positive = 3'h2,
    branch_if_signed_ge = 3'h3,
    branch_if_signed_less = 3'h4,
    branch_if_halfcarry_set = 3'h5,
    branch_if_halfcarry_clear = 3'h6,
    branch_if_transfer_bit_set = 3'h7
  } cbu_op_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_eval = 3'h2,
    st_jump = 3'h4
  } cbu_state_t;

endpackage

// ===== rtl/cbu_cond_eval.sv
`timescale 1ns/10ps
`default_nettype none
module cbu_cond_eval (
  // Branch selector and flags in, verdict out
  cbu_br_if.eval br
);
  import cbu_pkg::*;

  logic sign_lt; // Signed less-than from N xor V
  assign sign_lt = br.flags[FLG_N] ^ br.flags[FLG_V];

  // Pure decode, so the verdict is ready in the evaluate cycle
  always_comb begin
    case (br.op)
      branch_if_unsigned_lower: begin
        br.taken = br.flags[FLG_C];
      end
      branch_if_negative: begin
        br.taken = br.flags[FLG_N];
      end
      branch_if_positive: begin
        br.taken = ~br.flags[FLG_N];
      end
      branch_if_signed_ge: begin
        br.taken = ~sign_lt;
      end
      branch_if_signed_less: begin
        br.taken = sign_lt;
      end
      branch_if_halfcarry_set: begin
        br.taken = br.flags[FLG_H];
      end
      branch_if_halfcarry_clear: begin
        br.taken = ~br.flags[FLG_H];
      end
      branch_if_transfer_bit_set: begin
        br.taken = br.flags[FLG_T];
      end
      default: begin
        br.taken = 1'h0;
      end
    endcase
  end

endmodule // cbu_cond_eval
`default_nettype wire

// ===== rtl/cbu_pc_adder.sv
`timescale 1ns/10ps
`default_nettype none
module cbu_pc_adder (
  // Offset and program counter in, target out
  cbu_br_if.add br
);
  import cbu_pkg::*;

  logic [PC_W-1:0] ofs_sext; // Offset widened with its sign

  // Backward jumps need the sign copied up
  assign ofs_sext = {{(PC_W-OFS_W){br.offset[OFS_W-1]}}, br.offset};

  // Target wraps modulo the counter width
  assign br.target = br.pc + ofs_sext + PC_STEP;

endmodule // cbu_pc_adder
`default_nettype wire

// ===== rtl/cbu_top.sv
// Function
// - Lower branch jumps when carry is set
// - Minus branch jumps when negative is set
// - Plus branch jumps when negative is clear
// - Signed ge jumps when N xor V clear
// - Signed less jumps when N xor V set
// - Half-carry-set branch jumps when H set
// - Half-carry-clear branch jumps when H clear
// - Transfer branch jumps on T; flags untouched
`timescale 1ns/10ps
`default_nettype none
module cbu_top (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbu_pkg::ADDR_W-1:0] paddr,
  input wire logic [cbu_pkg::DATA_W-1:0] pwdata,
  output logic [cbu_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side view
  output logic [cbu_pkg::PC_W-1:0] pc_out,
  output logic busy,
  output logic done
);
  import cbu_pkg::*;

  // Address decode shared by error and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == ADR_CTRL) || (a == ADR_OFS) || (a == ADR_FLG) ||
              (a == ADR_PC) || (a == ADR_STAT);
  endfunction

  cbu_state_t state_reg; // Sequencer state
  cbu_state_t state_next; // Its next value
  cbu_op_t op_reg; // Branch under way or last run
  logic [OFS_W-1:0] ofs_reg; // Relative offset
  logic [FLG_W-1:0] flg_reg; // Status flag copy
  logic [PC_W-1:0] pc_reg; // Program counter
  logic [PC_W-1:0] pc_next; // Its next value
  logic taken_reg; // Last branch was taken
  logic [CYC_W-1:0] cyc_reg; // Cycles of last branch
  logic done_reg; // Completion pulse
  logic phase_reg; // Read data captured for this access
  logic [DATA_W-1:0] prdata_reg; // Read data holder
  logic [DATA_W-1:0] rd_next; // Read mux output
  logic wr_en; // Completing write
  logic idle; // Sequencer free
  logic start; // Go bit written while idle

  // Shared branch signals to the two helpers
  cbu_br_if br();

  assign br.op = op_reg;
  assign br.flags = flg_reg;
  assign br.offset = ofs_reg;
  assign br.pc = pc_reg;

  // Condition decode
  cbu_cond_eval u_eval (
    .br(br)
  );

  // Target arithmetic
  cbu_pc_adder u_adder (
    .br(br)
  );

  assign idle = (state_reg == st_idle);

  // Ready only after read data was captured a cycle earlier
  assign pready = clk_en & psel & penable & phase_reg;

  // Unmapped offsets answer with an error
  assign pslverr = pready & ~reg_hit(paddr);

  // Writes land only at the completing edge
  assign wr_en = pready & pwrite & reg_hit(paddr);

  // A branch starts only from idle; busy writes are dropped
  assign start = wr_en & idle & (paddr == ADR_CTRL) &
                 pwdata[CTRL_GO_BIT];

  // Read mux; unused bits read zero
  always_comb begin
    rd_next = '0;
    case (paddr)
      ADR_CTRL: begin
        rd_next[CTRL_OP_LSB +: OP_W] = op_reg;
      end
      ADR_OFS: begin
        rd_next[OFS_W-1:0] = ofs_reg;
      end
      ADR_FLG: begin
        rd_next[FLG_W-1:0] = flg_reg;
      end
      ADR_PC: begin
        rd_next[PC_W-1:0] = pc_reg;
      end
      ADR_STAT: begin
        rd_next[STAT_BUSY] = ~idle;
        rd_next[STAT_TAKEN] = taken_reg;
        rd_next[STAT_CYC_LSB +: CYC_W] = cyc_reg;
      end
      default: begin
        rd_next = '0;
      end
    endcase
  end

  // Read data capture in the setup cycle keeps prdata a flop with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 1'h0;
      prdata_reg <= '0;
    end else if (clk_en) begin
      if (pready) begin
        phase_reg <= 1'h0;
      end else if (psel && !phase_reg) begin
        phase_reg <= 1'h1;
        prdata_reg <= rd_next;
      end
    end
  end

  assign prdata = prdata_reg;

  // Branch selector; kept after the run for readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= branch_if_unsigned_lower;
    end else if (clk_en) begin
      if (wr_en && idle && paddr == ADR_CTRL) begin
        op_reg <= cbu_op_t'(pwdata[CTRL_OP_LSB +: OP_W]);
      end
    end
  end

  // Offset; frozen while busy so the target stays put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofs_reg <= OFS_RST;
    end else if (clk_en) begin
      if (wr_en && idle && paddr == ADR_OFS) begin
        ofs_reg <= pwdata[OFS_W-1:0];
      end
    end
  end

  // Flags; the branch itself never writes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flg_reg <= FLG_RST;
    end else if (clk_en) begin
      if (wr_en && idle && paddr == ADR_FLG) begin
        flg_reg <= pwdata[FLG_W-1:0] & FLG_MASK;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    case (state_reg)
      st_idle: begin
        state_next = start ? st_eval : st_idle;
      end
      st_eval: begin
        state_next = br.taken ? st_jump : st_idle;
      end
      st_jump: begin
        state_next = st_idle;
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Counter: step on fall through, load target on jump
  always_comb begin
    pc_next = pc_reg;
    if (state_reg == st_eval && !br.taken) begin
      pc_next = pc_reg + PC_STEP;
    end else if (state_reg == st_jump) begin
      pc_next = br.target;
    end else if (wr_en && idle && paddr == ADR_PC) begin
      pc_next = pwdata[PC_W-1:0];
    end
  end

  // Program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= PC_RST;
    end else if (clk_en) begin
      pc_reg <= pc_next;
    end
  end

  assign pc_out = pc_reg;

  // Outcome record for status readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_reg <= 1'h0;
      cyc_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == st_eval) begin
        taken_reg <= br.taken;
        cyc_reg <= br.taken ? CYC_TAKEN : CYC_FALL;
      end
    end
  end

  // Completion pulse, one enabled cycle long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'h0;
    end else if (clk_en) begin
      done_reg <= (state_reg == st_eval && !br.taken) ||
                  (state_reg == st_jump);
    end
  end

  assign done = done_reg;
  assign busy = ~idle;

  // Checks of the branch outcome per selector
  a_lower_carry: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en &&
     op_reg == branch_if_unsigned_lower)
    |=> ((state_reg == st_jump) == flg_reg[FLG_C]))
    else $error("lower branch ignores carry");

  a_minus_neg: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en && op_reg == branch_if_negative)
    |=> ((state_reg == st_jump) == flg_reg[FLG_N]))
    else $error("minus branch ignores negative");

  a_plus_neg: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en && op_reg == branch_if_positive)
    |=> ((state_reg == st_jump) == !flg_reg[FLG_N]))
    else $error("plus branch ignores negative");

  a_signed_ge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en && op_reg == branch_if_signed_ge)
    |=> ((state_reg == st_jump) ==
         !(flg_reg[FLG_N] ^ flg_reg[FLG_V])))
    else $error("signed ge branch wrong");

  a_signed_less: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en &&
     op_reg == branch_if_signed_less)
    |=> ((state_reg == st_jump) ==
         (flg_reg[FLG_N] ^ flg_reg[FLG_V])))
    else $error("signed less branch wrong");

  a_half_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en &&
     op_reg == branch_if_halfcarry_set && !flg_reg[FLG_H])
    |=> (state_reg == st_idle && pc_reg == $past(pc_reg) + PC_STEP))
    else $error("half set branch taken on clear");

  a_half_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en &&
     op_reg == branch_if_halfcarry_clear)
    |=> ((state_reg == st_jump) == !flg_reg[FLG_H]))
    else $error("half clear branch wrong");

  a_transfer_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en &&
     op_reg == branch_if_transfer_bit_set)
    |=> ((state_reg == st_jump) == flg_reg[FLG_T]))
    else $error("transfer branch ignores T");

  a_flags_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg != st_idle) |=> $stable(flg_reg))
    else $error("flags changed during branch");

  // Timing of both outcomes
  a_fall_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en && !br.taken)
    |=> (state_reg == st_idle && done_reg && cyc_reg == CYC_FALL))
    else $error("fall through not one cycle");

  a_taken_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_eval && clk_en && br.taken) ##1 clk_en
    |=> (state_reg == st_idle && done_reg &&
         pc_reg == $past(br.target) && cyc_reg == CYC_TAKEN))
    else $error("taken branch not two cycles");

  // Target arithmetic against an independent sum
  a_sext_target: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == st_jump) |->
    (br.target == PC_W'(pc_reg + PC_W'(signed'(ofs_reg)) + PC_STEP)))
    else $error("offset not sign extended");

endmodule // cbu_top
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cbu_pkg::*;
  // One branch case: inputs, then expected verdict
  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [FLG_W-1:0] flg;
    logic [OFS_W-1:0] ofs;
    logic [PC_W-1:0] pc;
    logic tk;
  } cbu_row_t;
  localparam int N_ROWS = 17;
  // Bench-driven inputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h00000000;
  // Observed outputs
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [PC_W-1:0] pc_out;
  logic busy;
  logic done;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  cbu_row_t rows [N_ROWS];
  logic [DATA_W-1:0] q;
  logic err;

  cbu_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_out(pc_out), .busy(busy), .done(done));

  // Clock at 4 ns
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compare with case inequality so unknowns fail
  task automatic chk(input string nm, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; idle edge first so strobes never double-assign
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    // A slave that never answers counts as a mismatch
    chk("pready", 32'(pready), 32'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Load one case, fire it, time it and check the outcome
  task automatic run_row(input cbu_row_t r);
    logic [PC_W-1:0] exp_pc;
    logic [CYC_W-1:0] cyc;
    int n;
    exp_pc = r.pc + PC_STEP;
    if (r.tk) begin
      exp_pc = r.pc + {{(PC_W-OFS_W){r.ofs[OFS_W-1]}}, r.ofs} + PC_STEP;
    end
    cyc = r.tk ? CYC_TAKEN : CYC_FALL;
    xfer(1'b1, ADR_PC, 32'(r.pc));
    xfer(1'b1, ADR_FLG, 32'(r.flg));
    xfer(1'b1, ADR_OFS, 32'(r.ofs));
    xfer(1'b1, ADR_CTRL, (32'h1 << CTRL_GO_BIT) | 32'(r.op));
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n == 1) chk("busy", 32'(busy), 32'h1);
    end while (done !== 1'b1 && n < 20);
    chk("cycles", n, 32'(cyc) + 1);
    chk("busy_end", 32'(busy), 32'h0);
    chk("pc_out", 32'(pc_out), 32'(exp_pc));
    // Completion pulse lasts exactly one cycle
    @(posedge pclk);
    chk("done_drop", 32'(done), 32'h0);
    xfer(1'b0, ADR_STAT, 32'h0);
    chk("stat", q, (32'(cyc) << STAT_CYC_LSB) |
        (32'(r.tk) << STAT_TAKEN));
    xfer(1'b0, ADR_FLG, 32'h0);
    chk("flags", q, 32'(r.flg & FLG_MASK));
  endtask

  // Port and register values while and after reset
  task automatic chk_reset();
    chk("rst_pc", 32'(pc_out), 32'(PC_RST));
    chk("rst_busy", 32'(busy), 32'h0);
    chk("rst_done", 32'(done), 32'h0);
    xfer(1'b0, ADR_OFS, 32'h0);
    chk("rst_ofs", q, 32'(OFS_RST));
    xfer(1'b0, ADR_FLG, 32'h0);
    chk("rst_flg", q, 32'(FLG_RST));
    xfer(1'b0, ADR_STAT, 32'h0);
    chk("rst_stat", q, 32'h0);
  endtask

  initial begin
    // Each selector taken and not taken, edge offsets and wrap
    rows = '{
      '{3'h0, 8'h01, 7'h05, 16'h0100, 1'b1},
      '{3'h0, 8'h6C, 7'h05, 16'h0100, 1'b0},
      '{3'h1, 8'h04, 7'h7F, 16'h0010, 1'b1},
      '{3'h1, 8'h69, 7'h7F, 16'h0010, 1'b0},
      '{3'h2, 8'h00, 7'h3F, 16'h0200, 1'b1},
      '{3'h2, 8'h04, 7'h3F, 16'h0200, 1'b0},
      '{3'h3, 8'h0C, 7'h40, 16'h0100, 1'b1},
      '{3'h3, 8'h04, 7'h40, 16'h0100, 1'b0},
      '{3'h3, 8'h08, 7'h40, 16'h0100, 1'b0},
      '{3'h4, 8'h08, 7'h01, 16'hFFFF, 1'b1},
      '{3'h4, 8'h0C, 7'h01, 16'hFFFF, 1'b0},
      '{3'h5, 8'h20, 7'h00, 16'h1234, 1'b1},
      '{3'h5, 8'h4D, 7'h00, 16'h1234, 1'b0},
      '{3'h6, 8'h4D, 7'h70, 16'h0008, 1'b1},
      '{3'h6, 8'h20, 7'h70, 16'h0008, 1'b0},
      '{3'h7, 8'h40, 7'h12, 16'hABCD, 1'b1},
      '{3'h7, 8'hBF, 7'h12, 16'hABCD, 1'b0}
    };
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    for (int i = 0; i < N_ROWS; i++) begin
      run_row(rows[i]);
    end
    // Go bit reads back zero, selector kept
    xfer(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl", q, 32'h7);
    // Unmapped place: error, zero data, no effect
    xfer(1'b1, 8'h14, 32'hFFFFFFFF);
    chk("wr_err", 32'(err), 32'h1);
    xfer(1'b0, 8'h14, 32'h0);
    chk("rd_err", 32'(err), 32'h1);
    chk("rd_zero", q, 32'h0);
    // Clock enable low stalls the answer
    clk_en <= 1'b0;
    fork
      xfer(1'b0, ADR_PC, 32'h0);
      begin
        repeat (6) @(posedge pclk);
        chk("stall_rdy", 32'(pready), 32'h0);
        clk_en <= 1'b1;
      end
    join
    // Last row falls through from 16'hABCD; bad write left it alone
    chk("stall_pc", q, 32'h0000ABCE);
    chk("stall_err", 32'(err), 32'h0);
    // Reset with the sequencer idle clears state
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
